// [verilog/td_pkg.sv]
// Package for the transfer descriptor header engine: header field layout,
// finish status codes, register offsets and reset values.
// Assumes a single clock domain and byte-addressed AXI4-Lite register access.
`default_nettype none
package td_pkg;
  // Header word 0 holds bytes 0..3, word 1 holds bytes 4..7, little endian.
  localparam int CNT_LSB = 0;
  localparam int TOGGLE_BIT = 10;
  localparam int ENABLE_BIT = 11;
  localparam int STATUS_LSB = 12;
  localparam int LIMIT_LSB = 16;
  localparam int SPEED_BIT = 26;
  localparam int LAST_BIT = 27;
  localparam int EP_LSB = 28;
  localparam int REQ_LSB = 0;
  localparam int TOKEN_LSB = 10;
  localparam int ALT_BIT = 14;
  localparam int PAIRED_BIT = 15;
  localparam int ADDR_LSB = 16;
  localparam int B7_LSB = 24;
  // Finish status codes.
  localparam logic [3:0] FINISH_OK = 4'h0;
  localparam logic [3:0] CRC_BAD = 4'h1;
  localparam logic [3:0] STUFF_VIOLATION = 4'h2;
  localparam logic [3:0] SEQUENCE_PID_MISMATCH = 4'h3;
  localparam logic [3:0] STALL_SEEN = 4'h4;
  localparam logic [3:0] PERIPHERAL_SILENT = 4'h5;
  localparam logic [3:0] PID_CHECK_BAD = 4'h6;
  localparam logic [3:0] PID_INVALID = 4'h7;
  localparam logic [3:0] PAYLOAD_TOO_LONG = 4'h8;
  localparam logic [3:0] PAYLOAD_TOO_SHORT = 4'h9;
  localparam logic [3:0] MEMORY_WRITE_TOO_SLOW = 4'hC;
  localparam logic [3:0] MEMORY_READ_TOO_SLOW = 4'hD;
  // Packet outcome encoding reported by the serial engine.
  localparam logic [3:0] OUT_ACK = 4'h0;
  localparam logic [3:0] OUT_CRC = 4'h1;
  localparam logic [3:0] OUT_STUFF = 4'h2;
  localparam logic [3:0] OUT_STALL = 4'h4;
  localparam logic [3:0] OUT_SILENT = 4'h5;
  localparam logic [3:0] OUT_PIDCHK = 4'h6;
  localparam logic [3:0] OUT_PIDBAD = 4'h7;
  localparam logic [3:0] OUT_MEMWR = 4'hC;
  localparam logic [3:0] OUT_MEMRD = 4'hD;
  // Register byte offsets.
  localparam logic [3:0] HDR0_OFS = 4'h0;
  localparam logic [3:0] HDR1_OFS = 4'h4;
  localparam logic [3:0] CTRL_OFS = 4'h8;
  localparam logic [3:0] STAT_OFS = 4'hC;
  localparam logic [1:0] LIST_APERIODIC = 2'h0;
  localparam logic [1:0] LIST_INTERRUPT = 2'h1;
  localparam logic [1:0] LIST_ISO = 2'h2;
  localparam logic [31:0] HDR_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] TOKEN_OUT = 2'h1;
  localparam logic [1:0] TOKEN_IN = 2'h2;
endpackage
`default_nettype wire

// [verilog/td_engine.sv]
// Transfer descriptor header engine: software loads an 8-byte header over
// AXI4-Lite; the engine issues packets to the serial engine and writes back
// count, status and toggle after each transaction, and clears enable when the descriptor finishes.
// Assumes the serial engine shares clock and answers one outcome per request.
// Function
// - Write bytes moved into transferred count.
// - Error-free finish reports code 0000.
// - CRC 0001, stuffing 0010, toggle mismatch 0011.
// - STALL reports 0100 and retires descriptor.
// - No response or handshake reports 0101.
// - PID check bits failing reports 0110.
// - Undefined or misplaced PID reports 0111.
// - Too much data reports 1000.
// - Short packet, buffer unfilled reports 1001.
// - IN storage too slow reports 1100.
// - OUT fetch too slow reports 1101.
// - Software sets enable; device clears when done.
// - Skip descriptors whose enable is clear.
// - Toggle picks DATA0/DATA1, checks IN PID.
// - Toggle flips only on successful packet.
// - Packet size limit caps each packet.
// - Tokens carry descriptor endpoint index.
// - Isochronous last bit marks list end.
// - Last bit ignored for other lists.
// - List-specific bits decoded per list type.
// - Speed bit selects full or low speed.
// - Requested count may span several packets.
// - Tokens carry descriptor device bus address.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`default_nettype none
module td_engine (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pkt_req,
  output logic [1:0] pkt_token,
  output logic [6:0] pkt_bus_address,
  output logic [3:0] pkt_endpoint_index,
  output logic pkt_low_speed,
  output logic pkt_data1,
  output logic [9:0] pkt_len,
  input wire logic pkt_done,
  input wire logic [3:0] pkt_outcome,
  input wire logic pkt_data1_seen,
  input wire logic [10:0] pkt_rx_len,
  output logic list_end,
  output logic [2:0] poll_interval_code,
  output logic [7:0] begin_frame_number,
  output logic paired,
  output logic alt_buffer
);
  typedef enum logic [1:0] {IDLE = 2'b00, ISSUE = 2'b01, WAIT = 2'b11} phase_t;
  typedef struct packed {
    logic [31:0] hdr0;
    logic [31:0] hdr1;
    logic [1:0] list_type;
    phase_t phase;
    logic aw_held;
    logic [3:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic pkt_req;
    logic [9:0] pkt_len;
    logic busy;
  } state_t;
  state_t st_reg;
  state_t st_next;

  // Apply byte strobes to a word.
  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w, input logic [3:0] stb);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (stb[i])
      begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Translate a packet outcome into a finish status code; reserved codes are unreachable.
  function automatic logic [3:0] status_of(input logic [3:0] oc, input logic mismatch, input logic too_long,
                                           input logic too_short);
    logic [3:0] c;
    c = td_pkg::FINISH_OK;
    case (oc)
      td_pkg::OUT_CRC: c = td_pkg::CRC_BAD;
      td_pkg::OUT_STUFF: c = td_pkg::STUFF_VIOLATION;
      td_pkg::OUT_STALL: c = td_pkg::STALL_SEEN;
      td_pkg::OUT_SILENT: c = td_pkg::PERIPHERAL_SILENT;
      td_pkg::OUT_PIDCHK: c = td_pkg::PID_CHECK_BAD;
      td_pkg::OUT_PIDBAD: c = td_pkg::PID_INVALID;
      td_pkg::OUT_MEMWR: c = td_pkg::MEMORY_WRITE_TOO_SLOW;
      td_pkg::OUT_MEMRD: c = td_pkg::MEMORY_READ_TOO_SLOW;
      td_pkg::OUT_ACK:
      begin
        if (mismatch)
          c = td_pkg::SEQUENCE_PID_MISMATCH;
        else if (too_long)
          c = td_pkg::PAYLOAD_TOO_LONG;
        else if (too_short)
          c = td_pkg::PAYLOAD_TOO_SHORT;
        else
          c = td_pkg::FINISH_OK;
      end
      default: c = td_pkg::PID_INVALID;
    endcase
    return c;
  endfunction

  // Decoded header fields.
  logic [9:0] moved;
  logic [9:0] limit;
  logic [9:0] requested;
  logic [9:0] remaining;
  logic [1:0] token;
  logic is_in;
  logic toggle;
  logic [10:0] rx_len;
  logic mismatch;
  logic too_long;
  logic too_short;
  logic [10:0] sent;
  logic [10:0] new_moved;
  logic [3:0] code;
  logic finished;
  assign moved = st_reg.hdr0[td_pkg::CNT_LSB +: 10];
  assign limit = st_reg.hdr0[td_pkg::LIMIT_LSB +: 10];
  assign requested = st_reg.hdr1[td_pkg::REQ_LSB +: 10];
  assign remaining = requested - moved;
  assign token = st_reg.hdr1[td_pkg::TOKEN_LSB +: 2];
  assign is_in = (token == td_pkg::TOKEN_IN);
  assign toggle = st_reg.hdr0[td_pkg::TOGGLE_BIT];
  assign rx_len = is_in ? pkt_rx_len : {1'b0, st_reg.pkt_len};
  assign mismatch = is_in && (pkt_data1_seen != toggle);
  assign too_long = is_in && ((rx_len > {1'b0, limit}) || (rx_len > {1'b0, remaining}));
  assign too_short = is_in && (rx_len < {1'b0, limit}) && (rx_len < {1'b0, remaining});
  assign sent = (too_long || pkt_outcome != td_pkg::OUT_ACK || mismatch) ? 11'h000 : rx_len;
  assign new_moved = {1'b0, moved} + sent;
  assign code = status_of(pkt_outcome, mismatch, too_long, too_short);
  assign finished = (code != td_pkg::FINISH_OK) || (new_moved >= {1'b0, requested});

  // Next-state logic: bus slave, then the descriptor sequencer.
  always_comb
  begin
    st_next = st_reg;
    if (st_reg.bvalid && s_axi_bready)
      st_next.bvalid = 1'b0;
    if (st_reg.rvalid && s_axi_rready)
      st_next.rvalid = 1'b0;
    if (s_axi_awvalid && !st_reg.aw_held)
    begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_held)
    begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    // Header writes while busy are dropped but still answered OKAY so the sequencer sees a stable descriptor.
    if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid)
    begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.rresp = st_reg.rresp;
      case ({st_reg.aw_addr[3:2], 2'b00})
        td_pkg::HDR0_OFS: if (!st_reg.busy) st_next.hdr0 = merge(st_reg.hdr0, st_reg.w_data, st_reg.w_strb);
        td_pkg::HDR1_OFS: if (!st_reg.busy) st_next.hdr1 = merge(st_reg.hdr1, st_reg.w_data, st_reg.w_strb);
        td_pkg::CTRL_OFS: if (!st_reg.busy && st_reg.w_strb[0]) st_next.list_type = st_reg.w_data[1:0];
        default: ;
      endcase
    end
    if (s_axi_arvalid && !st_reg.rvalid)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp = td_pkg::RESP_OKAY;
      case ({s_axi_araddr[3:2], 2'b00})
        td_pkg::HDR0_OFS: st_next.rdata = st_reg.hdr0;
        td_pkg::HDR1_OFS: st_next.rdata = st_reg.hdr1;
        td_pkg::CTRL_OFS: st_next.rdata = {30'h0000_0000, st_reg.list_type};
        td_pkg::STAT_OFS: st_next.rdata = {30'h0000_0000, st_reg.phase};
        default:
        begin
          st_next.rdata = 32'h0000_0000;
          st_next.rresp = td_pkg::RESP_SLVERR;
        end
      endcase
    end
    st_next.pkt_req = 1'b0;
    case (st_reg.phase)
      IDLE:
      begin
        st_next.busy = 1'b0;
        if (st_reg.hdr0[td_pkg::ENABLE_BIT] && !(st_next.aw_held && st_next.w_held))
        begin
          st_next.busy = 1'b1;
          st_next.phase = ISSUE;
        end
      end
      ISSUE:
      begin
        // Each packet is the smaller of the size limit and what is still owed.
        st_next.pkt_len = (limit < remaining) ? limit : remaining;
        st_next.pkt_req = 1'b1;
        st_next.phase = WAIT;
      end
      WAIT:
      begin
        if (pkt_done)
        begin
          st_next.hdr0[td_pkg::CNT_LSB +: 10] = new_moved[9:0];
          st_next.hdr0[td_pkg::STATUS_LSB +: 4] = code;
          if (code == td_pkg::FINISH_OK || code == td_pkg::PAYLOAD_TOO_SHORT)
            st_next.hdr0[td_pkg::TOGGLE_BIT] = ~toggle;
          if (finished)
          begin
            st_next.hdr0[td_pkg::ENABLE_BIT] = 1'b0;
            st_next.phase = IDLE;
          end
          else
          begin
            st_next.phase = ISSUE;
          end
        end
      end
      default: st_next.phase = IDLE;
    endcase
  end

  // State register; clock enable freezes everything.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg <= '0;
    end
    else if (clk_en)
    begin
      st_reg <= st_next;
    end
  end

  // Registered outputs.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pkt_token <= 2'h0;
      pkt_bus_address <= 7'h00;
      pkt_endpoint_index <= 4'h0;
      pkt_low_speed <= 1'b0;
      pkt_data1 <= 1'b0;
      list_end <= 1'b0;
      poll_interval_code <= 3'h0;
      begin_frame_number <= 8'h00;
      paired <= 1'b0;
      alt_buffer <= 1'b0;
    end
    else if (clk_en)
    begin
      pkt_token <= st_next.hdr1[td_pkg::TOKEN_LSB +: 2];
      pkt_bus_address <= st_next.hdr1[td_pkg::ADDR_LSB +: 7];
      pkt_endpoint_index <= st_next.hdr0[td_pkg::EP_LSB +: 4];
      pkt_low_speed <= st_next.hdr0[td_pkg::SPEED_BIT];
      pkt_data1 <= st_next.hdr0[td_pkg::TOGGLE_BIT];
      list_end <= (st_next.list_type == td_pkg::LIST_ISO) && st_next.hdr0[td_pkg::LAST_BIT];
      poll_interval_code <= (st_next.list_type == td_pkg::LIST_INTERRUPT) ? st_next.hdr1[31:29] : 3'h0;
      case (st_next.list_type)
        td_pkg::LIST_INTERRUPT: begin_frame_number <= {3'h0, st_next.hdr1[td_pkg::B7_LSB +: 5]};
        td_pkg::LIST_ISO: begin_frame_number <= st_next.hdr1[td_pkg::B7_LSB +: 8];
        default: begin_frame_number <= 8'h00;
      endcase
      paired <= (st_next.list_type == td_pkg::LIST_APERIODIC) && st_next.hdr1[td_pkg::PAIRED_BIT];
      alt_buffer <= (st_next.list_type == td_pkg::LIST_APERIODIC) && st_next.hdr1[td_pkg::ALT_BIT];
    end
  end

  assign s_axi_awready = !st_reg.aw_held;
  assign s_axi_wready = !st_reg.w_held;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = td_pkg::RESP_OKAY;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign pkt_req = st_reg.pkt_req;
  assign pkt_len = st_reg.pkt_len;

  // Checks on the sequencer. Each one watches state that the design drives.
  // A request lasts one enabled cycle; a frozen clock enable stretches it.
  sequence s_req_pulse;
    st_reg.pkt_req ##1 (!st_reg.pkt_req || !$past(clk_en));
  endsequence

  // Enable clear and skip, reserved status, length limit, toggle hold and count write-back after the answer.
  a_enable_clear: assert property (@(posedge clock) disable iff (!nrst)
    (clk_en && st_reg.phase == WAIT && pkt_done && finished) |=> !st_reg.hdr0[td_pkg::ENABLE_BIT])
    else $error("enable not cleared at finish");
  a_skip_disabled: assert property (@(posedge clock) disable iff (!nrst)
    (st_reg.phase == IDLE && !st_reg.hdr0[td_pkg::ENABLE_BIT]) |=> st_reg.phase == IDLE)
    else $error("sequencer left idle with enable clear");
  a_no_reserved: assert property (@(posedge clock) disable iff (!nrst)
    (clk_en && st_reg.phase == WAIT && pkt_done) |=> st_reg.hdr0[td_pkg::STATUS_LSB + 1 +: 3] != 3'b101)
    else $error("reserved status written");
  a_len_limit: assert property (@(posedge clock) disable iff (!nrst)
    st_reg.pkt_req |-> st_reg.pkt_len <= limit)
    else $error("packet longer than limit");
  a_toggle_hold: assert property (@(posedge clock) disable iff (!nrst)
    (clk_en && st_reg.phase == WAIT && pkt_done && code != td_pkg::FINISH_OK && code != td_pkg::PAYLOAD_TOO_SHORT)
    |=> st_reg.hdr0[td_pkg::TOGGLE_BIT] == $past(toggle))
    else $error("toggle changed on failed packet");
  a_count_write: assert property (@(posedge clock) disable iff (!nrst)
    (clk_en && st_reg.phase == WAIT && pkt_done) |=> moved == $past(new_moved[9:0]))
    else $error("count not written");
  // Status codes, retirement and the request pulse after ISSUE; an error or a short packet ends the descriptor.
  a_stall_code: assert property (@(posedge clock) disable iff (!nrst)
    (clk_en && st_reg.phase == WAIT && pkt_done && pkt_outcome == td_pkg::OUT_STALL)
    |=> st_reg.hdr0[td_pkg::STATUS_LSB +: 4] == td_pkg::STALL_SEEN && st_reg.phase == IDLE)
    else $error("stall not retired");
  a_silent_code: assert property (@(posedge clock) disable iff (!nrst)
    (clk_en && st_reg.phase == WAIT && pkt_done && pkt_outcome == td_pkg::OUT_SILENT)
    |=> st_reg.hdr0[td_pkg::STATUS_LSB +: 4] == td_pkg::PERIPHERAL_SILENT)
    else $error("silent code wrong");
  a_status_write: assert property (@(posedge clock) disable iff (!nrst)
    (clk_en && st_reg.phase == WAIT && pkt_done) |=> st_reg.hdr0[td_pkg::STATUS_LSB +: 4] == $past(code))
    else $error("status not written");
  a_short_retire: assert property (@(posedge clock) disable iff (!nrst)
    (clk_en && st_reg.phase == WAIT && pkt_done && code == td_pkg::PAYLOAD_TOO_SHORT)
    |=> st_reg.phase == IDLE && !st_reg.hdr0[td_pkg::ENABLE_BIT])
    else $error("short packet did not end the descriptor");
  a_issue_follows: assert property (@(posedge clock) disable iff (!nrst)
    (clk_en && st_reg.phase == ISSUE) |=> s_req_pulse)
    else $error("request pulse wrong");
  // The packet side must see the header that the sequencer works from.
  a_req_target: assert property (@(posedge clock) disable iff (!nrst)
    st_reg.pkt_req |-> pkt_endpoint_index == st_reg.hdr0[td_pkg::EP_LSB +: 4]
    && pkt_bus_address == st_reg.hdr1[td_pkg::ADDR_LSB +: 7])
    else $error("token target differs from header");
  a_req_data_pid: assert property (@(posedge clock) disable iff (!nrst)
    st_reg.pkt_req |-> pkt_data1 == st_reg.hdr0[td_pkg::TOGGLE_BIT]
    && pkt_low_speed == st_reg.hdr0[td_pkg::SPEED_BIT])
    else $error("data PID or speed differs from header");
  a_list_end: assert property (@(posedge clock) disable iff (!nrst)
    list_end |-> st_reg.list_type == td_pkg::LIST_ISO && st_reg.hdr0[td_pkg::LAST_BIT])
    else $error("list end shown outside an isochronous list");
endmodule // td_engine
`default_nettype wire

// [tb/serial_model.sv]
// Behavioural serial engine with the peripheral behind it.
// Assumes one outstanding packet: pkt_req pulses once, pkt_done answers once.
`default_nettype none
module serial_model (
  input wire logic clock,
  input wire logic pkt_req,
  input wire logic pkt_data1,
  input wire logic [9:0] pkt_len,
  input wire logic [3:0] cfg_outcome,
  input wire logic cfg_flip,
  input wire logic [10:0] cfg_rx,
  input wire logic [2:0] cfg_wait,
  output logic pkt_done,
  output logic [3:0] pkt_outcome,
  output logic pkt_data1_seen,
  output logic [10:0] pkt_rx_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cap_d1;
  logic [9:0] cap_len;
  // Quiet lines start from a known junk value; one process drives every answer line.
  // Outside the done cycle and the wait before it, outcome, data PID and length flip every cycle, so a stale sample never looks right.
  initial
  begin
    pkt_done = 1'b0;
    pkt_outcome = 4'hA;
    pkt_data1_seen = 1'b0;
    pkt_rx_len = 11'h2AA;
    forever
    begin
      @(posedge clock);
      if (pkt_req === 1'b1)
      begin
        cap_d1 = pkt_data1;
        cap_len = pkt_len;
        repeat (cfg_wait) @(posedge clock);
        pkt_done <= 1'b1;
        pkt_outcome <= cfg_outcome;
        pkt_data1_seen <= cap_d1 ^ cfg_flip;
        pkt_rx_len <= (cfg_rx == 11'h000) ? {1'b0, cap_len} : cfg_rx;
        @(posedge clock);
        pkt_done <= 1'b0;
      end
      pkt_outcome <= ~pkt_outcome;
      pkt_data1_seen <= ~pkt_data1_seen;
      pkt_rx_len <= ~pkt_rx_len;
    end
  end
endmodule // serial_model
`default_nettype wire

// [tb/host_transfer_descriptor_fields_tb.sv]
// Self-checking bench for the descriptor header engine.
// Assumes td_engine and serial_model are compiled first; one 200 MHz clock.
`default_nettype none
module host_transfer_descriptor_fields_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] e; logic [31:0] m;} note_t;
  logic clock = 1'b0, nrst = 1'b0, clk_en = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, pkt_token;
  logic pkt_req, pkt_low_speed, pkt_data1, pkt_done, pkt_data1_seen, list_end, paired, alt_buffer;
  logic [6:0] pkt_bus_address;
  logic [3:0] pkt_endpoint_index, pkt_outcome;
  logic [9:0] pkt_len;
  logic [10:0] pkt_rx_len;
  logic [2:0] poll_interval_code;
  logic [7:0] begin_frame_number;
  logic [3:0] cfg_outcome = 4'h0;
  logic cfg_flip = 1'b0;
  logic [10:0] cfg_rx = 11'h000;
  logic [2:0] cfg_wait = 3'h0;
  note_t rq[$];
  logic [31:0] pq[$];
  int n_errors = 0, tests_run = 0, cycles = 0;
  logic [3:0] codes [10] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hD, 4'h3};
  logic [31:0] dummy;

  td_engine u_dut (.*);
  serial_model u_model (.*);

  always #2.5 clock = ~clock;

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g, input logic [31:0] m);
    tests_run++;
    if ((g & m) !== (e & m))
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e & m, g & m);
    end
  endtask

  task automatic wrap_up();
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Write: address and data offered together, each dropped once taken.
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge clock);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    cmp("bresp", 32'(td_pkg::RESP_OKAY), 32'(s_axi_bresp), 32'h3);
    s_axi_bready <= 1'b0;
  endtask

  // Read: the expected word is noted first; the watcher below compares it.
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m, output logic [31:0] d);
    rq.push_back('{e, m});
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge clock);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask

  // Watchers take the oldest note whenever a read beat or a packet request shows.
  always @(posedge clock)
  begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && rq.size() > 0)
    begin
      cmp("rdata", rq[0].e, s_axi_rdata, rq[0].m);
      void'(rq.pop_front());
    end
    if (pkt_req === 1'b1)
    begin
      if (pq.size() == 0)
        cmp("stray pkt_req", 32'h0, 32'h1, 32'h1);
      else
        cmp("packet", pq.pop_front(), 32'({pkt_token, pkt_bus_address, pkt_endpoint_index, pkt_low_speed,
          pkt_data1, pkt_len}), 32'h01FF_FFFF);
    end
    cycles++;
    if (cycles == 30000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  // One descriptor run: peripheral answer set, header loaded, written-back header checked.
  task automatic run_td(input logic [1:0] tok, input logic [9:0] rqn, input logic [9:0] lm, input logic [3:0] oc,
    input logic [3:0] st, input logic fl, input logic tg, input logic cc, input logic [10:0] rx,
    input logic [9:0] cn, input int np);
    logic [31:0] d;
    logic [9:0] rem;
    logic [6:0] ad;
    logic [3:0] ep;
    logic sp;
    ad = 7'($urandom);
    ep = 4'($urandom);
    sp = 1'($urandom);
    rem = rqn;
    for (int i = 0; i < np; i++)
    begin
      pq.push_back(32'({tok, ad, ep, sp, 1'(i), (rem > lm) ? lm : rem}));
      rem = rem - lm;
    end
    @(posedge clock);
    cfg_outcome <= oc;
    cfg_flip <= fl;
    cfg_rx <= rx;
    cfg_wait <= 3'($urandom_range(3, 0));
    wr(td_pkg::HDR1_OFS, {8'h00, 1'b0, ad, 4'h0, tok, rqn});
    wr(td_pkg::HDR0_OFS, {ep, 1'b0, sp, lm, 4'h0, 1'b1, 1'b0, 10'h000});
    for (int k = 0; k < 100; k++)
    begin
      rd(td_pkg::HDR0_OFS, {ep, 1'b0, sp, lm, 16'h0000}, 32'hFFFF_0000, d);
      if (d[td_pkg::ENABLE_BIT] === 1'b0) break;
    end
    rd(td_pkg::HDR0_OFS, {ep, 1'b0, sp, lm, st, 1'b0, tg, cn}, cc ? 32'hFFFF_FFFF : 32'hFFFF_FC00,
      d);
    cmp("packets left", 32'h0, 32'(pq.size()), 32'hFFFF_FFFF);
  endtask

  // List-type decode: select the list, load byte 7 and the pairing bits, let the decode settle.
  task automatic lst(input logic [1:0] lt, input logic [31:0] w1);
    wr(td_pkg::CTRL_OFS, 32'(lt));
    wr(td_pkg::HDR1_OFS, w1);
    repeat (3) @(posedge clock);
  endtask

  initial
  begin
    void'($urandom(504));
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    rd(td_pkg::HDR0_OFS, td_pkg::HDR_RESET, 32'hFFFF_FFFF, dummy);
    rd(td_pkg::HDR1_OFS, td_pkg::HDR_RESET, 32'hFFFF_FFFF, dummy);
    wr(td_pkg::CTRL_OFS, 32'(td_pkg::LIST_APERIODIC));
    // Every outcome code once; code 3 is not defined on the engine side and must come back as 0111.
    foreach (codes[i])
      run_td(td_pkg::TOKEN_OUT, 10'h008, 10'h008, codes[i], (codes[i] == 4'h3) ? td_pkg::PID_INVALID : codes[i],
        1'b0, codes[i] == 4'h0, 1'b1, 11'h000, (codes[i] == 4'h0) ? 10'h008 : 10'h000,
        1);
    run_td(td_pkg::TOKEN_OUT, 10'h00A, 10'h004, 4'h0, td_pkg::FINISH_OK, 1'b0, 1'b1, 1'b1, 11'h000, 10'h00A, 3);
    run_td(td_pkg::TOKEN_IN, 10'h010, 10'h008, 4'h0, td_pkg::FINISH_OK, 1'b0, 1'b0, 1'b1, 11'h000, 10'h010, 2);
    run_td(td_pkg::TOKEN_IN, 10'h010, 10'h008, 4'h0, td_pkg::SEQUENCE_PID_MISMATCH, 1'b1, 1'b0, 1'b1, 11'h000,
      10'h000, 1);
    run_td(td_pkg::TOKEN_IN, 10'h010, 10'h008, 4'h0, td_pkg::PAYLOAD_TOO_SHORT, 1'b0, 1'b1, 1'b1, 11'h003,
      10'h003, 1);
    run_td(td_pkg::TOKEN_IN, 10'h010, 10'h008, 4'h0, td_pkg::PAYLOAD_TOO_LONG, 1'b0, 1'b0, 1'b1, 11'h009,
      10'h000, 1);
    // A header left disabled must never produce a packet.
    wr(td_pkg::HDR0_OFS, 32'h3008_0000);
    repeat (20) @(posedge clock);
    rd(td_pkg::HDR0_OFS, 32'h3008_0000, 32'hFFFF_FFFF, dummy);
    wr(td_pkg::HDR0_OFS, 32'h0800_0000);
    lst(td_pkg::LIST_ISO, 32'hA500_0000);
    cmp("list_end iso", 32'h1, 32'(list_end), 32'h1);
    cmp("frame iso", 32'hA5, 32'(begin_frame_number), 32'hFF);
    lst(td_pkg::LIST_INTERRUPT, 32'hA500_0000);
    cmp("list_end int", 32'h0, 32'(list_end), 32'h1);
    cmp("poll", 32'h5, 32'(poll_interval_code), 32'h7);
    cmp("frame int", 32'h5, 32'(begin_frame_number), 32'h1F);
    lst(td_pkg::LIST_APERIODIC, 32'h0000_C000);
    cmp("list_end aper", 32'h0, 32'(list_end), 32'h1);
    cmp("pairing", 32'h3, 32'({paired, alt_buffer}), 32'h3);
    wrap_up();
  end
endmodule // host_transfer_descriptor_fields_tb
`default_nettype wire
